/* File: logic/eer_bus_if.sv */
interface eer_bus_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: any enabled low driver wins
    assign scl = ~(scl_m_oe & ~scl_m_o);
    assign sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_d_oe & ~sda_d_o);

    modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
    modport host (input scl, input sda, output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe);
endinterface

/* File: logic/eer_dev.sv */
// Function
// - Location byte loads address during write
// - Master sends START, write address, location
// - Repeated START with read bit starts transmit
// - Device acknowledges every byte master sends; here write data bytes after the location get no acknowledge
// - First read byte from loaded location
// - Master ends read with NoACK, STOP
// - Master acknowledge makes device send next
// - Address advances per byte, wraps to zero
// - Small variant end behaviour left unspecified
// - Respond only to family prefix 1010
// - Select bits must be 000
// - Plain read starts at current address
// - Sender releases data line in ninth clock
module eer_dev #(
    parameter int MEM_BYTES = eer_pkg::MEM_BYTES_DFLT,
    localparam int AW = $clog2(MEM_BYTES)
) (
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, active low
    eer_bus_if.dev bus, // Two-wire bus
    input wire logic load_en, // Preload strobe
    input wire logic [AW-1:0] load_addr, // Preload location
    input wire logic [7:0] load_data, // Preload byte
    output logic busy // Frame in progress
);

    if (MEM_BYTES < 2 || MEM_BYTES > 256 || MEM_BYTES != (1 << AW)) begin
        $error("MEM_BYTES must be a power of two from 2 to 256");
    end

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic busy;
        logic hold;
        logic frst;
        logic [MEM_BYTES-1:0][7:0] mem;
    } eer_dev_sys_t;

    typedef struct packed {
        eer_pkg::eer_lst_t st;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic oe;
    } eer_dev_link_t;

    eer_dev_sys_t sr;
    eer_dev_sys_t sn;
    eer_dev_link_t lr;
    eer_dev_link_t ln;
    logic [AW-1:0] ptr_r;
    logic [AW-1:0] ptr_nxt;
    logic sda_pos_r;
    logic link_rst_n;
    logic start_det;
    logic stop_det;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;

    // System side: frame tracking and storage
    always_comb begin
        sn = sr;
        sn.scl_m = bus.scl;
        sn.scl_s = sr.scl_m;
        sn.sda_m = bus.sda;
        sn.sda_s = sr.sda_m;
        sn.sda_p = sr.sda_s;
        start_det = sr.scl_s & sr.sda_p & ~sr.sda_s;
        stop_det = sr.scl_s & ~sr.sda_p & sr.sda_s;
        if (start_det) begin
            sn.busy = 1'b1;
            sn.hold = 1'b1;
        end else if (stop_det) begin
            sn.busy = 1'b0;
            sn.hold = 1'b0;
        end else if (sr.hold && !sr.scl_s) begin
            sn.hold = 1'b0;
        end
        // Link logic stays in reset outside frames and across each START,
        // so a frame never depends on serial clock edges outside it
        sn.frst = ~sn.busy | sn.hold;
        // Storage changes only between frames, so the link side reads it as static
        if (load_en && !sr.busy) begin
            sn.mem[load_addr] = load_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr <= '{scl_m: 1'b1, scl_s: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
                    busy: 1'b0, hold: 1'b0, frst: 1'b1, mem: {MEM_BYTES{eer_pkg::MEM_ERASED}}};
        end else begin
            sr <= sn;
        end
    end

    assign busy = sr.busy;
    assign link_rst_n = rstn & ~sr.frst;

    // Data is taken on the rising serial clock edge
    always_ff @(posedge bus.scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_pos_r <= 1'b1;
        end else begin
            sda_pos_r <= bus.sda;
        end
    end

    assign byte_in = {lr.sh[6:0], sda_pos_r};
    // read data comes from the address held in the pointer
    assign rd_byte = sr.mem[ptr_r];

    // Link side: each falling edge closes one bit slot
    always_comb begin
        ln = lr;
        ptr_nxt = ptr_r;
        case (lr.st)
            eer_pkg::LS_DEV: begin
                ln.sh = byte_in;
                ln.cnt = lr.cnt + 3'h1;
                if (lr.cnt == 3'h7) begin
                    // family prefix and select bits must match
                    if (byte_in[7:4] == eer_pkg::DEV_PREFIX && byte_in[3:1] == eer_pkg::DEV_SELECT) begin
                        ln.st = eer_pkg::LS_DEVACK;
                        ln.rw = byte_in[0];
                        // pull low for the acknowledge slot
                        ln.oe = 1'b1;
                    end else begin
                        ln.st = eer_pkg::LS_IGN;
                    end
                end
            end
            eer_pkg::LS_DEVACK: begin
                ln.oe = 1'b0;
                // read bit switches to transmit from the current pointer
                if (lr.rw == eer_pkg::RW_READ) begin
                    ln.st = eer_pkg::LS_TX;
                    ln.sh = rd_byte;
                    ln.oe = ~rd_byte[7];
                end else begin
                    // write direction leads to the location byte
                    ln.st = eer_pkg::LS_LOC;
                end
            end
            eer_pkg::LS_LOC: begin
                ln.sh = byte_in;
                ln.cnt = lr.cnt + 3'h1;
                if (lr.cnt == 3'h7) begin
                    ptr_nxt = byte_in[AW-1:0];
                    ln.st = eer_pkg::LS_LOCACK;
                    ln.oe = 1'b1;
                end
            end
            eer_pkg::LS_LOCACK: begin
                // Data bytes of a write are not served here and are not acknowledged
                ln.oe = 1'b0;
                ln.st = eer_pkg::LS_IGN;
            end
            eer_pkg::LS_TX: begin
                ln.cnt = lr.cnt + 3'h1;
                if (lr.cnt == 3'h7) begin
                    // release the line for the master's answer
                    ln.oe = 1'b0;
                    ln.st = eer_pkg::LS_TXACK;
                    // pointer width makes the wrap to zero
                    ptr_nxt = ptr_r + AW'(1);
                end else begin
                    ln.sh = {lr.sh[6:0], 1'b0};
                    ln.oe = ~lr.sh[6];
                end
            end
            eer_pkg::LS_TXACK: begin
                // acknowledge from the master asks for the next byte
                if (sda_pos_r == eer_pkg::ACK_LVL) begin
                    ln.st = eer_pkg::LS_TX;
                    ln.sh = rd_byte;
                    ln.oe = ~rd_byte[7];
                end else begin
                    // no acknowledge, stay off the line until STOP
                    ln.oe = 1'b0;
                    ln.st = eer_pkg::LS_IGN;
                end
            end
            eer_pkg::LS_IGN: begin
                ln.oe = 1'b0;
            end
            default: begin
                ln.oe = 1'b0;
                ln.st = eer_pkg::LS_IGN;
            end
        endcase
    end

    always_ff @(negedge bus.scl or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lr <= '{st: eer_pkg::LS_DEV, cnt: 3'h0, sh: 8'h00, rw: 1'b0, oe: 1'b0};
        end else begin
            lr <= ln;
        end
    end

    // pointer survives STOP and repeated START, cleared only by system reset
    always_ff @(negedge bus.scl or negedge rstn) begin
        if (!rstn) begin
            ptr_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign bus.sda_d_o = 1'b0;
    assign bus.sda_d_oe = lr.oe;

endmodule

/* File: logic/eer_host.sv */
module eer_host #(
    parameter int QTR = eer_pkg::QTR_CYC
) (
    input wire logic clk, // System clock, also makes the serial clock
    input wire logic rstn, // Async reset, active low
    eer_bus_if.host bus, // Two-wire bus
    input wire logic rd_req, // Start a read
    input wire logic rd_sel, // 1: load location first
    input wire logic [7:0] rd_loc, // Location to load
    input wire logic [7:0] rd_len, // Bytes to read, 0 reads one
    output logic rd_ready, // Idle, request taken
    output logic [7:0] rd_data, // Received byte
    output logic rd_valid, // Byte strobe
    output logic rd_done, // End of transfer strobe
    output logic rd_nack // Device did not acknowledge
);

    // Below 8 cycles a START can reach the next clock fall before the device's synchronisers see it
    if (QTR < 8 || QTR > 255) begin
        $error("QTR must lie between 8 and 255 cycles");
    end

    typedef struct packed {
        eer_pkg::eer_mst_t st;
        logic [1:0] stg;
        logic [7:0] qc;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] left;
        logic [7:0] loc;
        logic scl_hi;
        logic sda_hi;
        logic sda_m;
        logic sda_s;
        logic [7:0] data;
        logic valid;
        logic done;
        logic nack;
    } eer_host_t;

    eer_host_t r;
    eer_host_t n;
    logic tick;

    always_comb begin
        n = r;
        n.sda_m = bus.sda;
        n.sda_s = r.sda_m;
        n.valid = 1'b0;
        n.done = 1'b0;
        tick = (r.qc == 8'(QTR - 1));
        if (r.st != eer_pkg::MS_IDLE) begin
            n.qc = tick ? 8'h00 : r.qc + 8'h01;
            if (tick) begin
                n.ph = r.ph + 2'h1;
            end
        end
        case (r.st)
            eer_pkg::MS_IDLE: begin
                n.scl_hi = 1'b1;
                n.sda_hi = 1'b1;
                if (rd_req) begin
                    n.st = eer_pkg::MS_START;
                    n.stg = rd_sel ? eer_pkg::STG_DEVW : eer_pkg::STG_DEVR;
                    n.loc = rd_loc;
                    n.left = (rd_len == 8'h00) ? 8'h01 : rd_len;
                    n.qc = 8'h00;
                    n.ph = 2'h0;
                    n.nack = 1'b0;
                end
            end
            eer_pkg::MS_START: begin
                if (tick) begin
                    case (r.ph)
                        2'h0: n.sda_hi = 1'b1;
                        2'h1: n.scl_hi = 1'b1;
                        2'h2: n.sda_hi = 1'b0;
                        default: begin
                            n.scl_hi = 1'b0;
                            n.st = eer_pkg::MS_WBYTE;
                            n.bitn = 4'h0;
                            // write direction to load, read direction after repeated START
                            n.sh = {eer_pkg::DEV_PREFIX, eer_pkg::DEV_SELECT,
                                    (r.stg == eer_pkg::STG_DEVW) ? eer_pkg::RW_WRITE : eer_pkg::RW_READ};
                        end
                    endcase
                end
            end
            eer_pkg::MS_WBYTE: begin
                if (tick) begin
                    case (r.ph)
                        // release the line in the ninth slot
                        2'h0: n.sda_hi = (r.bitn == 4'h8) ? 1'b1 : r.sh[7];
                        2'h1: n.scl_hi = 1'b1;
                        2'h2: begin
                            if (r.bitn == 4'h8) begin
                                n.nack = r.sda_s;
                            end
                        end
                        default: begin
                            n.scl_hi = 1'b0;
                            if (r.bitn != 4'h8) begin
                                n.bitn = r.bitn + 4'h1;
                                n.sh = {r.sh[6:0], 1'b0};
                            end else begin
                                n.bitn = 4'h0;
                                if (r.nack) begin
                                    n.st = eer_pkg::MS_STOP;
                                end else if (r.stg == eer_pkg::STG_DEVW) begin
                                    // location byte follows the write address
                                    n.stg = eer_pkg::STG_LOC;
                                    n.sh = r.loc;
                                end else if (r.stg == eer_pkg::STG_LOC) begin
                                    // new START in place of a data byte
                                    n.stg = eer_pkg::STG_DEVR;
                                    n.st = eer_pkg::MS_START;
                                end else begin
                                    n.stg = eer_pkg::STG_DATA;
                                    n.st = eer_pkg::MS_RBYTE;
                                end
                            end
                        end
                    endcase
                end
            end
            eer_pkg::MS_RBYTE: begin
                if (tick) begin
                    case (r.ph)
                        // acknowledge all but the last byte
                        2'h0: n.sda_hi = (r.bitn == 4'h8) ? (r.left == 8'h01) : 1'b1;
                        2'h1: n.scl_hi = 1'b1;
                        2'h2: begin
                            if (r.bitn != 4'h8) begin
                                n.sh = {r.sh[6:0], r.sda_s};
                            end
                        end
                        default: begin
                            n.scl_hi = 1'b0;
                            if (r.bitn == 4'h7) begin
                                n.data = r.sh;
                                n.valid = 1'b1;
                            end
                            if (r.bitn != 4'h8) begin
                                n.bitn = r.bitn + 4'h1;
                            end else begin
                                n.bitn = 4'h0;
                                n.left = r.left - 8'h01;
                                if (r.left == 8'h01) begin
                                    n.st = eer_pkg::MS_STOP;
                                end
                            end
                        end
                    endcase
                end
            end
            eer_pkg::MS_STOP: begin
                if (tick) begin
                    case (r.ph)
                        2'h0: n.sda_hi = 1'b0;
                        2'h1: n.scl_hi = 1'b1;
                        2'h2: n.sda_hi = 1'b1;
                        default: begin
                            n.st = eer_pkg::MS_IDLE;
                            n.done = 1'b1;
                        end
                    endcase
                end
            end
            default: n.st = eer_pkg::MS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r <= '{st: eer_pkg::MS_IDLE, stg: eer_pkg::STG_DEVW, qc: 8'h00, ph: 2'h0, bitn: 4'h0,
                   sh: 8'h00, left: 8'h00, loc: 8'h00, scl_hi: 1'b1, sda_hi: 1'b1, sda_m: 1'b1,
                   sda_s: 1'b1, data: 8'h00, valid: 1'b0, done: 1'b0, nack: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign rd_ready = (r.st == eer_pkg::MS_IDLE);
    assign rd_data = r.data;
    assign rd_valid = r.valid;
    assign rd_done = r.done;
    assign rd_nack = r.nack;
    assign bus.scl_m_o = 1'b0;
    assign bus.scl_m_oe = ~r.scl_hi;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = ~r.sda_hi;

endmodule

/* File: logic/eer_pkg.sv */
package eer_pkg;
    // Target address layout
    localparam logic [3:0] DEV_PREFIX = 4'hA;
    localparam logic [2:0] DEV_SELECT = 3'h0;
    localparam logic RW_WRITE = 1'h0;
    localparam logic RW_READ = 1'h1;
    // Level of the data line in the acknowledge slot
    localparam logic ACK_LVL = 1'h0;
    localparam logic [7:0] MEM_ERASED = 8'hFF;
    localparam int MEM_BYTES_DFLT = 256;
    // Serial clock timing, one quarter of a bit period
    localparam int CLK_NS = 25;
    localparam int SCL_QTR_NS = 200;
    localparam int QTR_CYC = (SCL_QTR_NS / CLK_NS < 1) ? 1 : SCL_QTR_NS / CLK_NS;
    // Byte stages of a host read
    localparam logic [1:0] STG_DEVW = 2'h0;
    localparam logic [1:0] STG_LOC = 2'h1;
    localparam logic [1:0] STG_DEVR = 2'h2;
    localparam logic [1:0] STG_DATA = 2'h3;

    typedef enum logic [6:0] {
        LS_DEV = 7'h01,
        LS_DEVACK = 7'h02,
        LS_LOC = 7'h04,
        LS_LOCACK = 7'h08,
        LS_TX = 7'h10,
        LS_TXACK = 7'h20,
        LS_IGN = 7'h40
    } eer_lst_t;

    typedef enum logic [4:0] {
        MS_IDLE = 5'h01,
        MS_START = 5'h02,
        MS_WBYTE = 5'h04,
        MS_RBYTE = 5'h08,
        MS_STOP = 5'h10
    } eer_mst_t;
endpackage

/* File: verification/eer_read_asserts.sv */
module eer_read_asserts (
    input wire logic clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic scl_m_o, // Host clock drive value
    input wire logic scl_m_oe, // Host pulls clock low
    input wire logic sda_m_o, // Host data drive value
    input wire logic sda_m_oe, // Host pulls data low
    input wire logic sda_d_o, // Device data drive value
    input wire logic sda_d_oe, // Device pulls data low
    input wire logic scl, // Resolved clock line
    input wire logic sda // Resolved data line
);
    timeunit 1ns;
    timeprecision 100ps;
    logic scl_q;
    logic rd_end;
    logic scl_rise;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic rw_r;

    assign scl_rise = scl & ~scl_q;

    // Bit and byte position within a frame; START and STOP both restart it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            bitn <= 4'h0;
            byten <= 2'h0;
            rw_r <= 1'b0;
            rd_end <= 1'b0;
        end else begin
            scl_q <= scl;
            if (scl && ($fell(sda) || $rose(sda))) begin
                bitn <= 4'h0;
                byten <= 2'h0;
                rd_end <= 1'b0;
            end else if (scl_rise) begin
                // After a refused data byte the next clock pulse belongs to STOP
                if (bitn == 4'h8 && byten != 2'h0 && rw_r && sda) begin
                    rd_end <= 1'b1;
                end
                bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
                if (bitn == 4'h8 && byten != 2'h3) begin
                    byten <= byten + 2'h1;
                end
                if (bitn == 4'h7 && byten == 2'h0) begin
                    rw_r <= sda;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_addr_acked: assert property (scl_rise && bitn == 4'h8 && byten == 2'h0 |-> !sda)
        else $error("address byte left unacknowledged");
    a_loc_acked: assert property (scl_rise && bitn == 4'h8 && byten == 2'h1 && !rw_r |-> !sda)
        else $error("location byte left unacknowledged");
    a_host_releases: assert property (scl_rise && bitn < 4'h8 && byten != 2'h0 && rw_r && !rd_end |-> !sda_m_oe)
        else $error("host drives data while device transmits");
    a_dev_releases: assert property (scl_rise && bitn == 4'h8 && byten != 2'h0 && rw_r |-> !sda_d_oe)
        else $error("device holds data line in host ack slot");
    a_dev_edge_low: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("device data changed while clock high");
    a_dev_open_drain: assert property (sda_d_o == 1'h0)
        else $error("device drives data line high");
    a_host_open_drain: assert property (scl_m_o == 1'h0 && sda_m_o == 1'h0)
        else $error("host drives a bus line high");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8] ##1 scl [*8])
        else $error("clock high phase too short");
    a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
    a_start_setup: assert property (scl && $fell(sda) |-> scl [*8])
        else $error("clock fell too soon after start");
endmodule

/* File: verification/i2c_eeprom_read_path_tb.sv */
module i2c_eeprom_read_path_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rd_req = 1'b0;
    logic rd_sel = 1'b0;
    logic [7:0] rd_loc = 8'h00;
    logic [7:0] rd_len = 8'h00;
    logic rd_ready;
    logic rd_valid;
    logic rd_done;
    logic rd_nack;
    logic [7:0] rd_data;
    logic load_en = 1'b0;
    logic [7:0] load_addr = 8'h00;
    logic [7:0] load_data = 8'h00;
    logic dev_busy;
    logic dev2_busy;
    int err_total = 0;
    int cmp_count = 0;
    logic [7:0] got[$];

    eer_bus_if bus ();
    // Second bus: the bench plays a host that sends two foreign addresses, then the device's own
    eer_bus_if bus2 ();

    always #12.5 clk = ~clk;

    eer_host eer_host_i (.clk(clk), .rstn(rstn), .bus(bus), .rd_req(rd_req), .rd_sel(rd_sel), .rd_loc(rd_loc),
        .rd_len(rd_len), .rd_ready(rd_ready), .rd_data(rd_data), .rd_valid(rd_valid), .rd_done(rd_done),
        .rd_nack(rd_nack));
    eer_dev eer_dev_i (.clk(clk), .rstn(rstn), .bus(bus), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .busy(dev_busy));
    eer_dev eer_dev_i2 (.clk(clk), .rstn(rstn), .bus(bus2), .load_en(1'b0), .load_addr(8'h00),
        .load_data(8'h00), .busy(dev2_busy));
    eer_read_asserts eer_read_asserts_i (.clk(clk), .rstn(rstn), .scl_m_o(bus.scl_m_o), .scl_m_oe(bus.scl_m_oe),
        .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe), .sda_d_o(bus.sda_d_o), .sda_d_oe(bus.sda_d_oe),
        .scl(bus.scl), .sda(bus.sda));

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cmp1(input string what, input logic exp, input logic seen);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic preload;
        logic [7:0] a[6];
        logic [7:0] d[6];
        a = '{8'h10, 8'hFE, 8'hFF, 8'h00, 8'h01, 8'h02};
        d = '{8'h5A, 8'h3C, 8'hC3, 8'h96, 8'h69, 8'hA5};
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            load_en <= 1'b1;
            load_addr <= a[i];
            load_data <= d[i];
        end
        @(posedge clk);
        load_en <= 1'b0;
    endtask

    // Bytes are gathered at the falling edge, where registered strobes have settled
    task automatic do_read(input logic sel, input logic [7:0] loc, input logic [7:0] n);
        got.delete();
        @(posedge clk);
        rd_req <= 1'b1;
        rd_sel <= sel;
        rd_loc <= loc;
        rd_len <= n;
        @(posedge clk);
        rd_req <= 1'b0;
        for (int k = 0; k < 20000; k++) begin
            @(negedge clk);
            if (rd_valid === 1'b1) got.push_back(rd_data);
            if (rd_valid === 1'b1 && got.size() == 1) cmp1("dev busy in frame", 1'b1, dev_busy);
            if (rd_done === 1'b1) break;
        end
        cmp1("rd_done", 1'b1, rd_done);
        cmp1("rd_ready", 1'b1, rd_ready);
        cmp1("dev busy after stop", 1'b0, dev_busy);
        cmp1("rd_nack", 1'b0, rd_nack);
        cmp8("byte count", n, 8'(got.size()));
    endtask

    task automatic s_sel_read;
        do_read(1'b1, 8'h10, 8'h01);
        cmp8("selective byte", 8'h5A, got[0]);
    endtask

    task automatic s_seq_wrap;
        logic [7:0] e[4];
        e = '{8'h3C, 8'hC3, 8'h96, 8'h69};
        do_read(1'b1, 8'hFE, 8'h04);
        for (int i = 0; i < 4; i++) begin
            cmp8("sequential byte", e[i], got[i]);
        end
    endtask

    task automatic s_cur_read;
        do_read(1'b0, 8'h00, 8'h01);
        cmp8("current address byte", 8'hA5, got[0]);
    endtask

    // One quarter of a bit period with the given clock and data levels
    task automatic q(input logic c, input logic d);
        bus2.scl_m_oe <= ~c;
        bus2.sda_m_oe <= ~d;
        repeat (8) @(posedge clk);
    endtask

    task automatic s_addr_filter;
        logic [7:0] a[3];
        logic e[3];
        logic ack;
        a = '{8'hA2, 8'hB0, 8'hA0};
        e = '{1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 3; i++) begin
            q(1'b1, 1'b1);
            q(1'b1, 1'b0);
            q(1'b0, 1'b0);
            for (int b = 7; b >= 0; b--) begin
                q(1'b0, a[i][b]);
                q(1'b1, a[i][b]);
                q(1'b1, a[i][b]);
                q(1'b0, a[i][b]);
            end
            q(1'b0, 1'b1);
            q(1'b1, 1'b1);
            ack = bus2.sda;
            q(1'b1, 1'b1);
            q(1'b0, 1'b1);
            cmp1("address ack level", e[i], ack);
            cmp1("foreign frame busy", 1'b1, dev2_busy);
            q(1'b0, 1'b0);
            q(1'b1, 1'b0);
            q(1'b1, 1'b1);
            cmp1("foreign frame closed", 1'b0, dev2_busy);
        end
    endtask

    initial begin
        bus2.scl_m_o <= 1'b0;
        bus2.scl_m_oe <= 1'b0;
        bus2.sda_m_o <= 1'b0;
        bus2.sda_m_oe <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        preload();
        s_sel_read();
        s_seq_wrap();
        s_cur_read();
        s_addr_filter();
        wrap_up();
    end

    // A complete run needs well under 10000 cycles
    initial begin
        repeat (50000) @(posedge clk);
        err_total++;
        wrap_up();
    end
endmodule
